//--- hdl/tpq_pkg.sv
// package: constants and carriers for the pixel quality classifier
package tpq_pkg;

    ////////////////////////////////////////
    // widths
    localparam int SAMPLE_W = 12;
    localparam int DIFF_W = SAMPLE_W + 1;
    localparam int SCALE_W = 16;
    localparam int IRR_W = SCALE_W + SAMPLE_W;
    localparam int RAD_W = 2 * SAMPLE_W;
    localparam int RATIO_W = 12;
    localparam int CMP_W = IRR_W + RATIO_W;
    localparam int PIX_CNT_W = 16;
    localparam int NUM_PHASES = 4;
    localparam int NUM_VERDICTS = 4;

    ////////////////////////////////////////
    // classification limits in lsb
    localparam logic [SAMPLE_W-1:0] MAX_SIGNAL_LSB = 12'h7D0;
    localparam logic [SAMPLE_W-1:0] NOISE_LSB = 12'h019;
    localparam logic [SAMPLE_W-1:0] AMP_GOOD_LSB = 12'h064;
    localparam logic [SAMPLE_W-1:0] AMP_OVER_LSB = MAX_SIGNAL_LSB;
    localparam logic [SAMPLE_W-1:0] AMP_NONE_LSB = NOISE_LSB;

    // ratio limits as linear factors, 20*log10(r): 60 db and 70 db
    localparam int AMR_EXCELLENT_DB = 60;
    localparam int AMR_SUFFICIENT_DB = 70;
    localparam logic [RATIO_W-1:0] AMR_60DB_RATIO = 12'h3E8;
    localparam logic [RATIO_W-1:0] AMR_70DB_RATIO = 12'hC5A;

    ////////////////////////////////////////
    // enumerations
    typedef enum logic [1:0] {
        TPQ_ACCEPT,
        TPQ_DECREASE,
        TPQ_INCREASE,
        TPQ_AMBIENT
    } tpq_verdict_t;

    typedef enum logic [1:0] {
        TPQ_AMP_NONE,
        TPQ_AMP_ENOUGH,
        TPQ_AMP_GOOD,
        TPQ_AMP_OVER
    } tpq_amp_class_t;

    typedef enum logic [1:0] {
        TPQ_AMR_EXCELLENT,
        TPQ_AMR_SUFFICIENT,
        TPQ_AMR_WEAK
    } tpq_amr_class_t;

    ////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic pixel_saturation_flag;
        logic signed [SAMPLE_W-1:0] zero_phase_sample;
        logic signed [SAMPLE_W-1:0] quarter_phase_sample;
        logic signed [SAMPLE_W-1:0] half_phase_sample;
        logic signed [SAMPLE_W-1:0] three_quarter_phase_sample;
    } tpq_pixel_t;

    typedef struct packed {
        logic frame_last;
        logic gray;
        logic sat;
        logic over;
        logic quiet;
        logic [SAMPLE_W-1:0] gray_value;
        logic [SAMPLE_W-1:0] ambient_value;
    } tpq_tag_t;

    typedef struct packed {
        tpq_verdict_t verdict;
        tpq_amp_class_t amp_class;
        tpq_amr_class_t amr_class;
        logic [SAMPLE_W-1:0] modulated_amplitude;
        logic [SAMPLE_W-1:0] gray_intensity;
        logic [IRR_W-1:0] ambient_irradiance;
        logic [IRR_W-1:0] modulated_irradiance;
    } tpq_result_t;

    typedef struct packed {
        tpq_verdict_t frame_verdict;
        logic short_frame;
        logic [NUM_VERDICTS-1:0][PIX_CNT_W-1:0] verdict_count;
    } tpq_summary_t;

endpackage : tpq_pkg

//--- hdl/tpq_isqrt.sv
// pipelined integer square root, one result bit per stage, tag carried alongside
`timescale 1ns/1ps
module tpq_isqrt #(
    parameter int RAD_W = 24,
    parameter int TAG_W = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    input wire logic [RAD_W-1:0] radicand,
    input wire logic [TAG_W-1:0] in_tag,
    output logic out_valid,
    output logic [RAD_W/2-1:0] root,
    output logic [TAG_W-1:0] out_tag
);
    localparam int ROOT_W = RAD_W / 2;
    localparam int REM_W = ROOT_W + 2;

    if (RAD_W % 2 != 0 || RAD_W < 4 || TAG_W < 1) begin : g_bad_param
        $error("tpq_isqrt: RAD_W must be even and at least 4, TAG_W at least 1");
    end

    logic [RAD_W-1:0] x [1:ROOT_W];
    logic [REM_W-1:0] r [1:ROOT_W];
    logic [ROOT_W-1:0] q [1:ROOT_W];
    logic v [1:ROOT_W];
    logic [TAG_W-1:0] tg [1:ROOT_W];

    ////////////////////////////////////////
    // one stage per result bit
    for (genvar gi = 0; gi < ROOT_W; gi++) begin : g_stage
        logic [RAD_W-1:0] x_in;
        logic [REM_W-1:0] r_in;
        logic [ROOT_W-1:0] q_in;
        logic v_in;
        logic [TAG_W-1:0] t_in;
        logic [REM_W-1:0] r_sh;
        logic [REM_W-1:0] trial;

        if (gi == 0) begin : g_first
            assign x_in = radicand;
            assign r_in = '0;
            assign q_in = '0;
            assign v_in = in_valid;
            assign t_in = in_tag;
        end else begin : g_next
            assign x_in = x[gi];
            assign r_in = r[gi];
            assign q_in = q[gi];
            assign v_in = v[gi];
            assign t_in = tg[gi];
        end

        // shift in two radicand bits, try 4q+1
        assign r_sh = {r_in[REM_W-3:0], x_in[RAD_W-1 -: 2]};
        assign trial = {q_in, 2'h1};

        always_ff @(posedge clk) begin
            if (!nrst) begin
                v[gi+1] <= 1'b0;
            end else begin
                v[gi+1] <= v_in;
            end
        end

        always_ff @(posedge clk) begin
            x[gi+1] <= {x_in[RAD_W-3:0], 2'h0};
            tg[gi+1] <= t_in;
            if (r_sh >= trial) begin
                r[gi+1] <= r_sh - trial;
                q[gi+1] <= {q_in[ROOT_W-2:0], 1'b1};
            end else begin
                r[gi+1] <= r_sh;
                q[gi+1] <= {q_in[ROOT_W-2:0], 1'b0};
            end
        end
    end

    assign out_valid = v[ROOT_W];
    assign root = q[ROOT_W];
    assign out_tag = tg[ROOT_W];

endmodule : tpq_isqrt

//--- hdl/tpq_classifier.sv
// host-side per-pixel validity and quality classifier for time-of-flight samples
//
// Overview of operation
// (RULE_01) The imager supplies per-pixel validity indicators, saturation flag among them.
// (RULE_02) Saturated pixel: discard and ask for shorter integration or less light.
// (RULE_03) Any sample magnitude above 2000 lsb: over limit, ask for shorter integration.
// (RULE_04) All sample magnitudes at or below 25 lsb: no object, ask for longer integration.
// (RULE_05) Checks run in order: saturation, max signal, noise, amplitude, ambient ratio.
// (RULE_06) Amplitude above 2000 lsb on a clean pixel: overexposed, decrease exposure.
// (RULE_07) Amplitude 100..2000 good, 25..100 enough, below 25 no object.
// (RULE_08) Ambient ratio in db is 20*log10 of ambient over modulated irradiance; optional.
// (RULE_09) Modulated irradiance is ac scale (sensitivity times time ratio) times amplitude.
// (RULE_10) Ratio below 60 db excellent, below 70 db sufficient.
// (RULE_11) Ratio above 70 db weak: ask for longer integration or more light.
// (RULE_12) Grayscale mode acquires only the zero-phase sample.
// (RULE_13) Grayscale mode reads pixels single-ended from the first gate.
// (RULE_14) One grayscale trigger gives exactly one frame of 12 bit values.
// (RULE_15) In grayscale mode the saturation flag is ignored.
// (RULE_16) Grayscale mode works with the light source off or on.
// (RULE_17) Ambient irradiance is dc scale (sensitivity times time ratio) times gray sample.
// (RULE_18) Amplitude is sqrt of squared phase differences each divided by 4.
// (RULE_19) Each pixel gets a verdict: accept, decrease, increase or excess ambient.
`timescale 1ns/1ps
module tpq_classifier #(
    parameter int FRAME_PIXELS = 0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic pix_valid,
    input wire tpq_pkg::tpq_pixel_t pix,
    input wire logic frame_last,
    input wire logic gray_mode,
    input wire logic [tpq_pkg::SAMPLE_W-1:0] ambient_sample,
    input wire logic [tpq_pkg::SCALE_W-1:0] ac_scale,
    input wire logic [tpq_pkg::SCALE_W-1:0] dc_scale,
    input wire logic amr_check_en,
    input wire logic amr_strict,
    output logic res_valid,
    output tpq_pkg::tpq_result_t res,
    output logic sum_valid,
    output tpq_pkg::tpq_summary_t summary
);
    localparam int TAG_W = $bits(tpq_pkg::tpq_tag_t);
    localparam int SUM_W = tpq_pkg::PIX_CNT_W + 2;

    if (FRAME_PIXELS < 0 || FRAME_PIXELS >= (1 << tpq_pkg::PIX_CNT_W)) begin : g_bad_param
        $error("tpq_classifier: FRAME_PIXELS out of counter range");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // stage a: magnitudes, limit checks, phase differences
    logic signed [tpq_pkg::SAMPLE_W-1:0] smp [tpq_pkg::NUM_PHASES];
    logic [tpq_pkg::SAMPLE_W-1:0] mag [tpq_pkg::NUM_PHASES];
    logic [tpq_pkg::NUM_PHASES-1:0] over_bit;
    logic [tpq_pkg::NUM_PHASES-1:0] quiet_bit;
    tpq_pkg::tpq_tag_t next_tag;
    logic signed [tpq_pkg::DIFF_W-1:0] next_d1;
    logic signed [tpq_pkg::DIFF_W-1:0] next_d2;

    assign smp[0] = pix.zero_phase_sample;
    assign smp[1] = pix.quarter_phase_sample;
    assign smp[2] = pix.half_phase_sample;
    assign smp[3] = pix.three_quarter_phase_sample;

    for (genvar gp = 0; gp < tpq_pkg::NUM_PHASES; gp++) begin : g_phase
        assign mag[gp] = smp[gp][tpq_pkg::SAMPLE_W-1] ? tpq_pkg::SAMPLE_W'(-smp[gp]) : smp[gp];
        // (RULE_03) per-sample max limit
        assign over_bit[gp] = mag[gp] > tpq_pkg::MAX_SIGNAL_LSB;
        // (RULE_04) per-sample noise floor
        assign quiet_bit[gp] = mag[gp] <= tpq_pkg::NOISE_LSB;
    end

    always_comb begin
        next_tag.frame_last = frame_last;
        next_tag.gray = gray_mode;
        // (RULE_15) flag ignored in gray
        // (RULE_01) flag taken per pixel
        next_tag.sat = pix.pixel_saturation_flag & ~gray_mode;
        // (RULE_12) gray uses zero phase only
        next_tag.over = gray_mode ? over_bit[0] : |over_bit;
        next_tag.quiet = gray_mode ? quiet_bit[0] : &quiet_bit;
        next_tag.gray_value = pix.zero_phase_sample;
        // (RULE_17) gray sample is ambient source
        next_tag.ambient_value = gray_mode ? pix.zero_phase_sample : ambient_sample;
        // (RULE_18) 180-0 and 270-90
        next_d1 = {smp[2][tpq_pkg::SAMPLE_W-1], smp[2]} - {smp[0][tpq_pkg::SAMPLE_W-1], smp[0]};
        next_d2 = {smp[3][tpq_pkg::SAMPLE_W-1], smp[3]} - {smp[1][tpq_pkg::SAMPLE_W-1], smp[1]};
    end

    logic a_valid;
    tpq_pkg::tpq_tag_t a_tag;
    logic signed [tpq_pkg::DIFF_W-1:0] a_d1;
    logic signed [tpq_pkg::DIFF_W-1:0] a_d2;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            a_valid <= 1'b0;
        end else begin
            a_valid <= pix_valid;
        end
    end

    always_ff @(posedge clk) begin
        a_tag <= next_tag;
        a_d1 <= next_d1;
        a_d2 <= next_d2;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // stage b: radicand = (d1^2 + d2^2) / 4
    logic signed [2*tpq_pkg::DIFF_W-1:0] sq1;
    logic signed [2*tpq_pkg::DIFF_W-1:0] sq2;
    logic [2*tpq_pkg::DIFF_W:0] sum_sq;
    logic b_valid;
    tpq_pkg::tpq_tag_t b_tag;
    logic [tpq_pkg::RAD_W-1:0] b_rad;

    // (RULE_18) squared differences over 4
    assign sq1 = a_d1 * a_d1;
    assign sq2 = a_d2 * a_d2;
    assign sum_sq = (2*tpq_pkg::DIFF_W+1)'(unsigned'(sq1)) + (2*tpq_pkg::DIFF_W+1)'(unsigned'(sq2));

    always_ff @(posedge clk) begin
        if (!nrst) begin
            b_valid <= 1'b0;
        end else begin
            b_valid <= a_valid;
        end
    end

    always_ff @(posedge clk) begin
        b_tag <= a_tag;
        b_rad <= sum_sq[tpq_pkg::RAD_W+1:2];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // square root pipeline
    logic s_valid;
    logic [tpq_pkg::SAMPLE_W-1:0] s_amp;
    logic [TAG_W-1:0] s_tag_bits;
    tpq_pkg::tpq_tag_t s_tag;

    tpq_isqrt #(
        .RAD_W(tpq_pkg::RAD_W),
        .TAG_W(TAG_W)
    ) u_isqrt (
        .clk(clk),
        .nrst(nrst),
        .in_valid(b_valid),
        .radicand(b_rad),
        .in_tag(b_tag),
        .out_valid(s_valid),
        .root(s_amp),
        .out_tag(s_tag_bits)
    );

    assign s_tag = tpq_pkg::tpq_tag_t'(s_tag_bits);

    ////////////////////////////////////////////////////////////////////////////////
    // stage c: irradiances
    logic c_valid;
    tpq_pkg::tpq_tag_t c_tag;
    logic [tpq_pkg::SAMPLE_W-1:0] c_amp;
    logic [tpq_pkg::IRR_W-1:0] c_mod_irr;
    logic [tpq_pkg::IRR_W-1:0] c_amb_irr;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            c_valid <= 1'b0;
        end else begin
            c_valid <= s_valid;
        end
    end

    always_ff @(posedge clk) begin
        c_tag <= s_tag;
        c_amp <= s_amp;
        // (RULE_09) ac scale times amplitude
        c_mod_irr <= tpq_pkg::IRR_W'(ac_scale) * tpq_pkg::IRR_W'(s_amp);
        // (RULE_17) dc scale times ambient value: gray sample in gray mode, else ambient_sample
        c_amb_irr <= tpq_pkg::IRR_W'(dc_scale) * tpq_pkg::IRR_W'(s_tag.ambient_value);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // stage d: classification
    logic [tpq_pkg::CMP_W-1:0] lim_60db;
    logic [tpq_pkg::CMP_W-1:0] lim_70db;
    logic [tpq_pkg::CMP_W-1:0] amb_wide;
    tpq_pkg::tpq_amr_class_t next_amr;
    tpq_pkg::tpq_amp_class_t next_amp;
    tpq_pkg::tpq_verdict_t next_verdict;
    logic amr_fail;

    always_comb begin
        // (RULE_08) log compare as linear products
        lim_60db = tpq_pkg::CMP_W'(c_mod_irr) * tpq_pkg::CMP_W'(tpq_pkg::AMR_60DB_RATIO);
        lim_70db = tpq_pkg::CMP_W'(c_mod_irr) * tpq_pkg::CMP_W'(tpq_pkg::AMR_70DB_RATIO);
        amb_wide = tpq_pkg::CMP_W'(c_amb_irr);
        // (RULE_10) excellent and sufficient bands
        // (RULE_11) weak above 70 db
        if (amb_wide > lim_70db) begin
            next_amr = tpq_pkg::TPQ_AMR_WEAK;
        end else if (amb_wide >= lim_60db) begin
            next_amr = tpq_pkg::TPQ_AMR_SUFFICIENT;
        end else begin
            next_amr = tpq_pkg::TPQ_AMR_EXCELLENT;
        end
        amr_fail = amr_check_en &&
            (amr_strict ? next_amr != tpq_pkg::TPQ_AMR_EXCELLENT : next_amr == tpq_pkg::TPQ_AMR_WEAK);
        // (RULE_07) amplitude bands
        if (c_amp > tpq_pkg::AMP_OVER_LSB) begin
            next_amp = tpq_pkg::TPQ_AMP_OVER;
        end else if (c_amp >= tpq_pkg::AMP_GOOD_LSB) begin
            next_amp = tpq_pkg::TPQ_AMP_GOOD;
        end else if (c_amp >= tpq_pkg::AMP_NONE_LSB) begin
            next_amp = tpq_pkg::TPQ_AMP_ENOUGH;
        end else begin
            next_amp = tpq_pkg::TPQ_AMP_NONE;
        end
        // (RULE_05) fixed priority chain
        if (c_tag.sat) begin
            // (RULE_02) saturation dumps pixel
            next_verdict = tpq_pkg::TPQ_DECREASE;
        end else if (c_tag.over) begin
            // (RULE_03) over max signal
            next_verdict = tpq_pkg::TPQ_DECREASE;
        end else if (c_tag.quiet) begin
            // (RULE_04) below noise floor
            next_verdict = tpq_pkg::TPQ_INCREASE;
        end else if (c_tag.gray) begin
            // (RULE_16) gray needs no modulation checks
            next_verdict = tpq_pkg::TPQ_ACCEPT;
        end else if (next_amp == tpq_pkg::TPQ_AMP_OVER) begin
            // (RULE_06) overexposure
            next_verdict = tpq_pkg::TPQ_DECREASE;
        end else if (next_amp == tpq_pkg::TPQ_AMP_NONE) begin
            // (RULE_07) no object
            next_verdict = tpq_pkg::TPQ_INCREASE;
        end else if (amr_fail) begin
            // (RULE_11) too much ambient light
            next_verdict = tpq_pkg::TPQ_AMBIENT;
        end else begin
            next_verdict = tpq_pkg::TPQ_ACCEPT;
        end
    end

    // (RULE_19) verdict aligned with pixel data
    always_ff @(posedge clk) begin
        if (!nrst) begin
            res_valid <= 1'b0;
            res <= '0;
        end else begin
            res_valid <= c_valid;
            if (c_valid) begin
                res.verdict <= next_verdict;
                res.amp_class <= c_tag.gray ? tpq_pkg::TPQ_AMP_NONE : next_amp;
                res.amr_class <= next_amr;
                res.modulated_amplitude <= c_amp;
                // (RULE_14) 12 bit intensity per pixel
                res.gray_intensity <= c_tag.gray_value;
                res.ambient_irradiance <= c_amb_irr;
                res.modulated_irradiance <= c_mod_irr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // per-frame verdict counts
    logic [tpq_pkg::PIX_CNT_W-1:0] cnt [tpq_pkg::NUM_VERDICTS];
    logic [tpq_pkg::NUM_VERDICTS-1:0][tpq_pkg::PIX_CNT_W-1:0] next_cnt;
    logic [SUM_W-1:0] total;
    tpq_pkg::tpq_verdict_t frame_verdict;

    for (genvar gv = 0; gv < tpq_pkg::NUM_VERDICTS; gv++) begin : g_count
        logic hit;

        assign hit = c_valid && next_verdict == tpq_pkg::tpq_verdict_t'(gv);
        assign next_cnt[gv] = (hit && cnt[gv] != '1) ? cnt[gv] + 1'b1 : cnt[gv];

        always_ff @(posedge clk) begin
            if (!nrst) begin
                cnt[gv] <= '0;
            end else if (c_valid && c_tag.frame_last) begin
                cnt[gv] <= '0;
            end else begin
                cnt[gv] <= next_cnt[gv];
            end
        end
    end

    always_comb begin
        total = SUM_W'(next_cnt[0]) + SUM_W'(next_cnt[1]) + SUM_W'(next_cnt[2]) + SUM_W'(next_cnt[3]);
        if (next_cnt[tpq_pkg::TPQ_DECREASE] != '0) begin
            frame_verdict = tpq_pkg::TPQ_DECREASE;
        end else if (next_cnt[tpq_pkg::TPQ_INCREASE] != '0) begin
            frame_verdict = tpq_pkg::TPQ_INCREASE;
        end else if (next_cnt[tpq_pkg::TPQ_AMBIENT] != '0) begin
            frame_verdict = tpq_pkg::TPQ_AMBIENT;
        end else begin
            frame_verdict = tpq_pkg::TPQ_ACCEPT;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sum_valid <= 1'b0;
            summary <= '0;
        end else begin
            sum_valid <= c_valid && c_tag.frame_last;
            if (c_valid && c_tag.frame_last) begin
                summary.frame_verdict <= frame_verdict;
                summary.short_frame <= FRAME_PIXELS != 0 && total != SUM_W'(FRAME_PIXELS);
                summary.verdict_count <= next_cnt;
            end
        end
    end

endmodule : tpq_classifier

//--- sim/tpq_classifier_props.sv
// checker: port properties of the pixel quality classifier
`timescale 1ns/1ps
module tpq_classifier_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic pix_valid,
    input wire tpq_pkg::tpq_pixel_t pix,
    input wire logic frame_last,
    input wire logic gray_mode,
    input wire logic res_valid,
    input wire tpq_pkg::tpq_result_t res,
    input wire logic sum_valid
);
    function automatic logic [11:0] mag(input logic signed [11:0] s);
        return s[11] ? 12'(-s) : 12'(s);
    endfunction : mag
    logic [3:0] ov;
    logic [3:0] lo;
    logic any_over;
    logic all_low;
    logic sat_live;
    for (genvar g = 0; g < 4; g++) begin : g_mag
        assign ov[g] = mag(pix[47-12*g -: 12]) > 12'h7D0;
        assign lo[g] = mag(pix[47-12*g -: 12]) <= 12'h019;
    end
    assign sat_live = pix.pixel_saturation_flag && !gray_mode;
    assign any_over = ov[0] || (!gray_mode && |ov);
    assign all_low = lo[0] && (gray_mode || &lo);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    a_res_latency: assert property (pix_valid |-> ##16 res_valid)
        else $error("result missing 16 cycles after pixel");
    a_no_stray: assert property (res_valid |-> $past(pix_valid, 16))
        else $error("result without a pixel");
    a_sat_decrease: assert property (pix_valid && sat_live |-> ##16 res.verdict == tpq_pkg::TPQ_DECREASE)
        else $error("saturated pixel not decrease");
    a_max_signal: assert property (pix_valid && !sat_live && any_over |-> ##16 res.verdict == tpq_pkg::TPQ_DECREASE)
        else $error("sample over limit not decrease");
    a_noise_floor: assert property (pix_valid && !sat_live && all_low |-> ##16 res.verdict == tpq_pkg::TPQ_INCREASE)
        else $error("quiet pixel not increase");
    a_gray_accept: assert property (pix_valid && gray_mode && !any_over && !all_low
        |-> ##16 res.verdict == tpq_pkg::TPQ_ACCEPT)
        else $error("gray pixel not accepted");
    a_amp_over: assert property (res_valid && res.amp_class == tpq_pkg::TPQ_AMP_OVER
        |-> res.verdict == tpq_pkg::TPQ_DECREASE && res.modulated_amplitude > 12'h7D0)
        else $error("overexposed amplitude mishandled");
    a_amp_good: assert property (res_valid && res.amp_class == tpq_pkg::TPQ_AMP_GOOD
        |-> res.modulated_amplitude >= 12'h064 && res.modulated_amplitude <= 12'h7D0)
        else $error("good class out of range");
    a_frame_sum: assert property (pix_valid && frame_last |-> ##16 sum_valid && res_valid)
        else $error("frame summary missing");
    c_ambient: cover property (res_valid && res.verdict == tpq_pkg::TPQ_AMBIENT);
    c_summary: cover property (sum_valid);
    c_saturated: cover property (pix_valid && sat_live);
endmodule : tpq_classifier_props

bind tpq_classifier tpq_classifier_props i_props (.clk(clk), .nrst(nrst), .pix_valid(pix_valid), .pix(pix),
    .frame_last(frame_last), .gray_mode(gray_mode), .res_valid(res_valid), .res(res), .sum_valid(sum_valid));

//--- sim/tpq_imager_model.sv
// imager model: presents one pixel per cycle to the classifier
`timescale 1ns/1ps
module tpq_imager_model (
    input wire logic clk,
    output logic pix_valid,
    output tpq_pkg::tpq_pixel_t pix,
    output logic frame_last,
    output logic gray_mode
);
    initial begin
        pix_valid = 1'b0;
        pix = '0;
        frame_last = 1'b0;
        gray_mode = 1'b0;
    end
    task automatic present(input logic sat, input logic gray, input logic last, input logic signed [11:0] s0,
        input logic signed [11:0] s1, input logic signed [11:0] s2, input logic signed [11:0] s3);
        @(posedge clk);
        pix_valid <= 1'b1;
        gray_mode <= gray;
        frame_last <= last;
        pix <= '{sat, s0, gray ? ~s0 : s1, gray ? s0 : s2, gray ? ~s0 : s3};
    endtask : present
    task automatic idle();
        @(posedge clk);
        pix_valid <= 1'b0;
        frame_last <= 1'b0;
        pix <= ~pix;
    endtask : idle
endmodule : tpq_imager_model

//--- sim/tpq_classifier_tb.sv
// testbench: scenarios for the pixel quality classifier
`timescale 1ns/1ps
module tpq_classifier_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic pix_valid;
    tpq_pkg::tpq_pixel_t pix;
    logic frame_last;
    logic gray_mode;
    logic [11:0] ambient_sample = 12'h000;
    logic [15:0] ac_scale = 16'h0003;
    logic [15:0] dc_scale = 16'h0001;
    logic amr_check_en = 1'b0;
    logic amr_strict = 1'b0;
    logic res_valid;
    tpq_pkg::tpq_result_t res;
    logic sum_valid;
    tpq_pkg::tpq_summary_t summary;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;

    tpq_imager_model i_tpq_imager_model (.clk(clk), .pix_valid(pix_valid), .pix(pix), .frame_last(frame_last),
        .gray_mode(gray_mode));
    tpq_classifier #(.FRAME_PIXELS(3)) i_tpq_classifier (.clk(clk), .nrst(nrst), .pix_valid(pix_valid), .pix(pix),
        .frame_last(frame_last), .gray_mode(gray_mode), .ambient_sample(ambient_sample), .ac_scale(ac_scale),
        .dc_scale(dc_scale), .amr_check_en(amr_check_en), .amr_strict(amr_strict), .res_valid(res_valid),
        .res(res), .sum_valid(sum_valid), .summary(summary));

    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_total++;
            give_verdict();
        end
    end
    ////////////////////////////////////////
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", err_total, checks);
        if (err_total == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict
    task automatic cmp_verdict(input tpq_pkg::tpq_verdict_t got, input tpq_pkg::tpq_verdict_t exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_verdict
    task automatic cmp_val(input logic [27:0] got, input logic [27:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_val
    task automatic wait_out(input bit want_sum);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while ((want_sum ? sum_valid : res_valid) !== 1'b1 && n < 40);
        if (n >= 40) begin
            err_total++;
        end
    endtask : wait_out
    task automatic run_pix(input logic sat, input logic gray, input int s0, input int s1, input int s2, input int s3);
        i_tpq_imager_model.present(sat, gray, 1'b0, 12'(s0), 12'(s1), 12'(s2), 12'(s3));
        i_tpq_imager_model.idle();
        wait_out(1'b0);
    endtask : run_pix
    task automatic set_amr(input logic en, input logic strict, input logic [15:0] dc, input logic [11:0] amb);
        @(posedge clk);
        amr_check_en <= en;
        amr_strict <= strict;
        dc_scale <= dc;
        ambient_sample <= amb;
        run_pix(1'b0, 1'b0, 0, 0, 200, 0);
    endtask : set_amr
    ////////////////////////////////////////
    task automatic t_gray_frame();
        i_tpq_imager_model.present(1'b0, 1'b1, 1'b0, 12'sd500, 12'sd0, 12'sd0, 12'sd0);
        i_tpq_imager_model.present(1'b1, 1'b1, 1'b0, 12'sd500, 12'sd0, 12'sd0, 12'sd0);
        i_tpq_imager_model.present(1'b0, 1'b1, 1'b1, 12'sd10, 12'sd0, 12'sd0, 12'sd0);
        i_tpq_imager_model.idle();
        wait_out(1'b1);
        cmp_verdict(summary.frame_verdict, tpq_pkg::TPQ_INCREASE);
        cmp_val(28'(summary.verdict_count[0]), 28'h2);
        cmp_val(28'(summary.verdict_count[2]), 28'h1);
        cmp_val(28'(summary.short_frame), 28'h0);
        cmp_val(28'(res.gray_intensity), 28'hA);
    endtask : t_gray_frame
    task automatic t_saturation();
        run_pix(1'b1, 1'b0, 500, 0, 0, 0);
        cmp_verdict(res.verdict, tpq_pkg::TPQ_DECREASE);
        run_pix(1'b1, 1'b0, 10, 0, 0, 0);
        cmp_verdict(res.verdict, tpq_pkg::TPQ_DECREASE);
        run_pix(1'b1, 1'b1, 500, 0, 0, 0);
        cmp_verdict(res.verdict, tpq_pkg::TPQ_ACCEPT);
    endtask : t_saturation
    task automatic t_signal_limits();
        run_pix(1'b0, 1'b0, 0, -2001, 0, 0);
        cmp_verdict(res.verdict, tpq_pkg::TPQ_DECREASE);
        run_pix(1'b0, 1'b0, 0, 2000, 0, 0);
        cmp_verdict(res.verdict, tpq_pkg::TPQ_ACCEPT);
        cmp_val(28'(res.modulated_amplitude), 28'h3E8);
        run_pix(1'b0, 1'b0, 25, -25, 25, -25);
        cmp_verdict(res.verdict, tpq_pkg::TPQ_INCREASE);
    endtask : t_signal_limits
    task automatic t_amplitude();
        run_pix(1'b0, 1'b0, -1900, -1900, 1900, 1900);
        cmp_verdict(res.verdict, tpq_pkg::TPQ_DECREASE);
        cmp_val(28'(res.amp_class), 28'(tpq_pkg::TPQ_AMP_OVER));
        run_pix(1'b0, 1'b0, 26, 26, 26, 26);
        cmp_verdict(res.verdict, tpq_pkg::TPQ_INCREASE);
        cmp_val(28'(res.amp_class), 28'(tpq_pkg::TPQ_AMP_NONE));
        run_pix(1'b0, 1'b0, 0, 0, 198, 0);
        cmp_val(28'(res.amp_class), 28'(tpq_pkg::TPQ_AMP_ENOUGH));
        cmp_verdict(res.verdict, tpq_pkg::TPQ_ACCEPT);
        run_pix(1'b0, 1'b0, 0, 0, 200, 0);
        cmp_val(28'(res.amp_class), 28'(tpq_pkg::TPQ_AMP_GOOD));
        cmp_val(res.modulated_irradiance, 28'h12C);
    endtask : t_amplitude
    task automatic t_ambient();
        set_amr(1'b1, 1'b0, 16'h0001, 12'h064);
        cmp_val(28'(res.amr_class), 28'(tpq_pkg::TPQ_AMR_EXCELLENT));
        cmp_val(res.ambient_irradiance, 28'h64);
        set_amr(1'b1, 1'b0, 16'h0FA0, 12'h064);
        cmp_val(28'(res.amr_class), 28'(tpq_pkg::TPQ_AMR_SUFFICIENT));
        cmp_verdict(res.verdict, tpq_pkg::TPQ_ACCEPT);
        set_amr(1'b1, 1'b1, 16'h0FA0, 12'h064);
        cmp_verdict(res.verdict, tpq_pkg::TPQ_AMBIENT);
        set_amr(1'b1, 1'b0, 16'h03E8, 12'hFA0);
        cmp_val(28'(res.amr_class), 28'(tpq_pkg::TPQ_AMR_WEAK));
        cmp_verdict(res.verdict, tpq_pkg::TPQ_AMBIENT);
        cmp_val(res.ambient_irradiance, 28'h3D0900);
        set_amr(1'b0, 1'b0, 16'h03E8, 12'hFA0);
        cmp_verdict(res.verdict, tpq_pkg::TPQ_ACCEPT);
    endtask : t_ambient
    ////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_gray_frame();
        t_saturation();
        t_signal_limits();
        t_amplitude();
        t_ambient();
        give_verdict();
    end
endmodule : tpq_classifier_tb
